// ===== design/pms_oreg.v
// Reset-loaded output register used for every control output of the sequencer.
// Assumes a synchronous active-high reset on the shared system clock.
`timescale 1ns/1ps
module pms_oreg #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);

   always @(posedge clk) begin
      if (rst) begin
         q <= RST_VAL;
      end else begin
         q <= d;
      end
   end

endmodule

// ===== design/pms_regs.vh
// Constants shared by the power mode sequencer: state codes, stop selects,
// reset values and timing counts. Assumes a 100 MHz system clock.
`ifndef PMS_REGS_VH
`define PMS_REGS_VH

// One-hot mode state codes.
`define PMS_ST_W          8
`define PMS_ST_RUN        8'h01
`define PMS_ST_WAIT       8'h02
`define PMS_ST_STOP       8'h04
`define PMS_ST_PSTOP_BUS  8'h08
`define PMS_ST_PSTOP_GATE 8'h10
`define PMS_ST_SLOW_RUN   8'h20
`define PMS_ST_SLOW_WAIT  8'h40
`define PMS_ST_SLOW_STOP  8'h80

// Bit positions of the one-hot state vector.
`define PMS_B_RUN        0
`define PMS_B_WAIT       1
`define PMS_B_STOP       2
`define PMS_B_PSTOP_BUS  3
`define PMS_B_PSTOP_GATE 4
`define PMS_B_SLOW_RUN   5
`define PMS_B_SLOW_WAIT  6
`define PMS_B_SLOW_STOP  7

// Stop flavour select, sampled at the sleep instruction.
`define PMS_STOPSEL_NORMAL    2'h0
`define PMS_STOPSEL_BUS_GATED 2'h1
`define PMS_STOPSEL_BUS_RUN   2'h2

// Clock rates and the derived flash access spacing in very-low-power modes.
`define PMS_SYS_CLK_MHZ     100
`define PMS_FLASH_VLP_MHZ   1
`define PMS_IRC_CORE_MHZ    4
`define PMS_FLASH_DIV_CYC   (`PMS_SYS_CLK_MHZ / `PMS_FLASH_VLP_MHZ)
`define PMS_FLASH_CNT_W     7
// Last count of the flash divider, one below the divider period.
`define PMS_FLASH_LAST      7'h63

// Reset values of the control outputs (normal run).
`define PMS_RST_CLK_EN   3'h7
`define PMS_RST_DET_EN   1'h1
`define PMS_RST_ZERO     1'h0
`define PMS_RST_ONE      1'h1

`endif

// ===== design/pms_sequencer.v
// Power mode sequencer: run, wait, stop, two partial stops and the three
// very-low-power modes, with the clock gates and analog controls for each.
// Assumes all inputs are synchronous to clk and the core holds its state
// while its clock is gated.
//
// Functional notes
// - Sleep instruction picks wait or stop by select.
// - Each run mode has own wait, stop.
// - Pin states held across every sleeping mode.
// - Normal wait gates core clock, interrupt resumes.
// - Normal stop static, registers kept, detector on.
// - Bus-running partial stop keeps bus clock alive.
// - Bus-gated partial stop stops masters and slaves.
// - Partial stops keep prior clock generator, regulator.
// - Very-low-power run slows flash, regulator low, detector off.
// - Very-low-power run allows internal oscillator core clock.
// - Bias off in low-power run/wait with continuous converter.
// - Low-power wait sleeps core, interrupt returns.
// - Low-power stop static, detector off, interrupt recovers.
// - Low-power stop keeps converter, pin interrupts, timers.
`timescale 1ns/1ps
`include "pms_regs.vh"
module pms_sequencer (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Core sleep interface
   input wire wait_for_interrupt_instr,
   input wire deep_sleep_select,
   input wire irq_pending,
   // Mode configuration
   input wire vlp_run_req,
   input wire [1:0] stop_select,
   input wire dcdc_continuous,
   // Mode status
   output wire [`PMS_ST_W-1:0] mode_state,
   output wire core_wake,
   // Clock gates
   output wire core_clk_en,
   output wire sys_clk_en,
   output wire bus_clk_en,
   output wire periph_stop,
   // Power and analog controls
   output wire low_voltage_detect_en,
   output wire regulator_low_power,
   output wire clock_generator_unit_vlp,
   output wire flash_slow_access,
   output wire flash_access_strobe,
   output wire irc_core_src_allow,
   output wire bias_en,
   output wire io_hold,
   output wire adc_pin_irq_en,
   output wire lp_periph_allow
);

   localparam [`PMS_ST_W-1:0] S_RUN = `PMS_ST_RUN;
   localparam [`PMS_ST_W-1:0] S_WAIT = `PMS_ST_WAIT;
   localparam [`PMS_ST_W-1:0] S_STOP = `PMS_ST_STOP;
   localparam [`PMS_ST_W-1:0] S_PSTOP_BUS = `PMS_ST_PSTOP_BUS;
   localparam [`PMS_ST_W-1:0] S_PSTOP_GATE = `PMS_ST_PSTOP_GATE;
   localparam [`PMS_ST_W-1:0] S_SLOW_RUN = `PMS_ST_SLOW_RUN;
   localparam [`PMS_ST_W-1:0] S_SLOW_WAIT = `PMS_ST_SLOW_WAIT;
   localparam [`PMS_ST_W-1:0] S_SLOW_STOP = `PMS_ST_SLOW_STOP;
   localparam [`PMS_FLASH_CNT_W-1:0] FLASH_LAST = `PMS_FLASH_LAST;

   reg [`PMS_ST_W-1:0] state_r;
   reg [`PMS_ST_W-1:0] state_nxt;
   reg from_vlp_r;
   reg from_vlp_nxt;
   reg wake_nxt;
   reg [`PMS_FLASH_CNT_W-1:0] flash_cnt_r;
   reg [`PMS_FLASH_CNT_W-1:0] flash_cnt_nxt;
   reg strobe_nxt;

   wire vlp_origin;
   wire in_partial;
   wire vlp_active;
   wire [2:0] clk_en_nxt;
   wire periph_stop_nxt;
   wire det_nxt;
   wire irc_nxt;
   wire bias_nxt;
   wire hold_nxt;
   wire [2:0] clk_en_q;

   // A stop flavour selected from very-low-power run always lands in the
   // low-power stop unless a partial stop was asked for explicitly.
   always @* begin
      state_nxt = state_r;
      from_vlp_nxt = from_vlp_r;
      wake_nxt = 1'b0;
      case (state_r)
         S_RUN: begin
            if (wait_for_interrupt_instr) begin
               from_vlp_nxt = 1'b0;
               if (!deep_sleep_select) begin
                  state_nxt = S_WAIT;
               end else if (stop_select == `PMS_STOPSEL_BUS_RUN) begin
                  state_nxt = S_PSTOP_BUS;
               end else if (stop_select == `PMS_STOPSEL_BUS_GATED) begin
                  state_nxt = S_PSTOP_GATE;
               end else begin
                  state_nxt = S_STOP;
               end
            end else if (vlp_run_req) begin
               state_nxt = S_SLOW_RUN;
            end
         end
         S_SLOW_RUN: begin
            if (wait_for_interrupt_instr) begin
               from_vlp_nxt = 1'b1;
               if (!deep_sleep_select) begin
                  state_nxt = S_SLOW_WAIT;
               end else if (stop_select == `PMS_STOPSEL_BUS_RUN) begin
                  state_nxt = S_PSTOP_BUS;
               end else if (stop_select == `PMS_STOPSEL_BUS_GATED) begin
                  state_nxt = S_PSTOP_GATE;
               end else begin
                  state_nxt = S_SLOW_STOP;
               end
            end else if (!vlp_run_req) begin
               state_nxt = S_RUN;
            end
         end
         S_WAIT, S_STOP: begin
            if (irq_pending) begin
               state_nxt = S_RUN;
               wake_nxt = 1'b1;
            end
         end
         S_SLOW_WAIT, S_SLOW_STOP: begin
            if (irq_pending) begin
               state_nxt = S_SLOW_RUN;
               wake_nxt = 1'b1;
            end
         end
         S_PSTOP_BUS, S_PSTOP_GATE: begin
            if (irq_pending) begin
               state_nxt = from_vlp_r ? S_SLOW_RUN : S_RUN;
               wake_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = S_RUN;
            from_vlp_nxt = 1'b0;
         end
      endcase
   end

   // Outputs are derived from the next state so they change in the same
   // cycle as mode_state, never one cycle late.
   assign vlp_origin = state_nxt[`PMS_B_PSTOP_BUS] | state_nxt[`PMS_B_PSTOP_GATE] ? from_vlp_nxt : 1'b0;
   assign in_partial = state_nxt[`PMS_B_PSTOP_BUS] | state_nxt[`PMS_B_PSTOP_GATE];
   // Partial stops inherit the regulator and generator state of their origin.
   assign vlp_active = state_nxt[`PMS_B_SLOW_RUN] | state_nxt[`PMS_B_SLOW_WAIT] | state_nxt[`PMS_B_SLOW_STOP]
                       | (in_partial & vlp_origin);

   // Clock enables: {bus, system, core}.
   assign clk_en_nxt[0] = state_nxt[`PMS_B_RUN] | state_nxt[`PMS_B_SLOW_RUN];
   assign clk_en_nxt[1] = clk_en_nxt[0] | state_nxt[`PMS_B_WAIT] | state_nxt[`PMS_B_SLOW_WAIT];
   assign clk_en_nxt[2] = clk_en_nxt[1] | state_nxt[`PMS_B_PSTOP_BUS];
   assign periph_stop_nxt = state_nxt[`PMS_B_STOP] | state_nxt[`PMS_B_SLOW_STOP]
                            | state_nxt[`PMS_B_PSTOP_GATE];
   assign det_nxt = ~vlp_active;
   assign irc_nxt = state_nxt[`PMS_B_SLOW_RUN] | state_nxt[`PMS_B_SLOW_WAIT];
   assign bias_nxt = ~(irc_nxt & dcdc_continuous);
   // Pads keep their levels in every sleeping mode, so gated logic cannot glitch them.
   assign hold_nxt = ~clk_en_nxt[0];

   pms_oreg #(.W(`PMS_ST_W), .RST_VAL(`PMS_ST_RUN)) u_state (
      .clk(clk),
      .rst(rst),
      .d(state_nxt),
      .q(mode_state)
   );

   pms_oreg #(.W(3), .RST_VAL(`PMS_RST_CLK_EN)) u_clk (
      .clk(clk),
      .rst(rst),
      .d(clk_en_nxt),
      .q(clk_en_q)
   );

   assign core_clk_en = clk_en_q[0];
   assign sys_clk_en = clk_en_q[1];
   assign bus_clk_en = clk_en_q[2];
   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ZERO)) u_pstop (
      .clk(clk),
      .rst(rst),
      .d(periph_stop_nxt),
      .q(periph_stop)
   );
   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_DET_EN)) u_det (
      .clk(clk),
      .rst(rst),
      .d(det_nxt),
      .q(low_voltage_detect_en)
   );

   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ZERO)) u_reg_lp (
      .clk(clk),
      .rst(rst),
      .d(vlp_active),
      .q(regulator_low_power)
   );

   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ZERO)) u_cgu (
      .clk(clk),
      .rst(rst),
      .d(vlp_active),
      .q(clock_generator_unit_vlp)
   );

   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ZERO)) u_flash_slow (
      .clk(clk),
      .rst(rst),
      .d(vlp_active),
      .q(flash_slow_access)
   );

   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ZERO)) u_irc (
      .clk(clk),
      .rst(rst),
      .d(irc_nxt),
      .q(irc_core_src_allow)
   );

   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ONE)) u_bias (
      .clk(clk),
      .rst(rst),
      .d(bias_nxt),
      .q(bias_en)
   );

   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ZERO)) u_hold (
      .clk(clk),
      .rst(rst),
      .d(hold_nxt),
      .q(io_hold)
   );

   // Converter and pin interrupts stay usable in every mode, including the
   // low-power stop, so any mode can be woken from a pin.
   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ONE)) u_adc (
      .clk(clk),
      .rst(rst),
      .d(1'b1),
      .q(adc_pin_irq_en)
   );

   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ONE)) u_lpp (
      .clk(clk),
      .rst(rst),
      .d(1'b1),
      .q(lp_periph_allow)
   );

   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ZERO)) u_wake (
      .clk(clk),
      .rst(rst),
      .d(wake_nxt),
      .q(core_wake)
   );

   // Flash access strobe: every cycle at full speed, once per divider period
   // in very-low-power modes. The counter restarts on entry so the first slow
   // access is a full period after the switch.
   always @* begin
      flash_cnt_nxt = {`PMS_FLASH_CNT_W{1'b0}};
      strobe_nxt = 1'b1;
      if (vlp_active) begin
         strobe_nxt = (flash_cnt_r == FLASH_LAST);
         if (flash_cnt_r != FLASH_LAST) begin
            flash_cnt_nxt = flash_cnt_r + 1'b1;
         end
      end
   end

   pms_oreg #(.W(1), .RST_VAL(`PMS_RST_ONE)) u_strobe (
      .clk(clk),
      .rst(rst),
      .d(strobe_nxt),
      .q(flash_access_strobe)
   );

   always @(posedge clk) begin
      if (rst) begin
         state_r <= S_RUN;
         from_vlp_r <= 1'b0;
         flash_cnt_r <= {`PMS_FLASH_CNT_W{1'b0}};
      end else begin
         state_r <= state_nxt;
         from_vlp_r <= from_vlp_nxt;
         flash_cnt_r <= flash_cnt_nxt;
      end
   end

endmodule

// ===== tb/pms_core_model.sv
// Core model: issues the sleep instruction and raises interrupts on command.
// Assumes the bench pulses each command for one clock.
`timescale 1ns/1ps
module pms_core_model (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Bench commands
   input wire sleep_go,
   input wire irq_go,
   // Core clock gate
   input wire core_clk_en,
   // Core sleep outputs
   output reg sleep_instr = 1'b0,
   output reg irq = 1'b0
);
   // A gated core cannot execute, so the sleep instruction only issues while it is clocked.
   always @(posedge clk) begin
      sleep_instr <= !rst && sleep_go && core_clk_en;
      irq <= !rst && irq_go;
   end
endmodule

// ===== tb/pms_seq_props.sv
// Checker for the power mode sequencer, watching only its ports.
// Assumes it is bound to pms_sequencer and shares its clock and reset.
`timescale 1ns/1ps
`include "pms_regs.vh"
module pms_seq_props (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Block inputs
   input wire wait_for_interrupt_instr,
   input wire deep_sleep_select,
   input wire irq_pending,
   input wire [1:0] stop_select,
   input wire dcdc_continuous,
   // Block outputs
   input wire [`PMS_ST_W-1:0] mode_state,
   input wire core_wake,
   input wire core_clk_en,
   input wire sys_clk_en,
   input wire bus_clk_en,
   input wire periph_stop,
   input wire low_voltage_detect_en,
   input wire regulator_low_power,
   input wire flash_access_strobe,
   input wire irc_core_src_allow,
   input wire bias_en,
   input wire io_hold,
   input wire adc_pin_irq_en,
   input wire lp_periph_allow
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire [7:0] ms = mode_state;
   wire go = wait_for_interrupt_instr;
   wire ds = deep_sleep_select;
   sequence s_nap;
      ms[0] && go && !ds;
   endsequence
   sequence s_vnap;
      ms[5] && go && !ds;
   endsequence
   a_wait_entry:
   assert property (s_nap |=> ms == 8'h02) else $error("Wait not entered.");
   a_stop_entry:
   assert property (ms[0] && go && ds && (stop_select == 2'h0 || stop_select == 2'h3) |=> ms == 8'h04)
      else $error("Stop not entered.");
   a_slow_wait:
   assert property (s_vnap |=> ms == 8'h40) else $error("Slow wait not entered.");
   a_run_wake:
   assert property ((ms[1] || ms[2]) && irq_pending |=> ms == 8'h01 && core_wake) else $error("No wake to run.");
   a_vlp_wake:
   assert property ((ms[6] || ms[7]) && irq_pending |=> ms == 8'h20 && core_wake)
      else $error("No wake to slow run.");
   a_wait_clocks:
   assert property (ms[1] || ms[6] |-> !core_clk_en && sys_clk_en && bus_clk_en) else $error("Wait clocks wrong.");
   a_pstop_bus:
   assert property (ms[3] |-> bus_clk_en && !sys_clk_en && !periph_stop) else $error("Bus clock lost.");
   a_pstop_gate:
   assert property (ms[4] |-> !bus_clk_en && periph_stop) else $error("Bus not gated.");
   a_stop_detect:
   assert property (ms[2] || ms[7] |-> periph_stop && low_voltage_detect_en == ms[2]) else $error("Stop detector wrong.");
   a_vlp_ctrl:
   assert property (ms[5] |-> !low_voltage_detect_en && regulator_low_power && irc_core_src_allow)
      else $error("Slow run controls wrong.");
   a_bias_off:
   assert property ((ms[5] || ms[6]) && dcdc_continuous && $past(dcdc_continuous) |-> !bias_en)
      else $error("Bias left on.");
   a_bias_level:
   assert property (bias_en == !((ms[5] || ms[6]) && $past(dcdc_continuous))) else $error("Bias level wrong.");
   a_io_held:
   assert property (io_hold == !core_clk_en) else $error("Pins not held.");
   a_strobe_gap:
   assert property (flash_access_strobe && regulator_low_power |=> !flash_access_strobe || !regulator_low_power)
      else $error("Flash strobe too fast.");
   a_always_on:
   assert property (adc_pin_irq_en && lp_periph_allow) else $error("Wake sources off.");
endmodule

bind pms_sequencer pms_seq_props pms_seq_props_i (.clk(clk), .rst(rst),
   .wait_for_interrupt_instr(wait_for_interrupt_instr), .deep_sleep_select(deep_sleep_select),
   .irq_pending(irq_pending), .stop_select(stop_select), .dcdc_continuous(dcdc_continuous),
   .mode_state(mode_state), .core_wake(core_wake), .core_clk_en(core_clk_en), .sys_clk_en(sys_clk_en),
   .bus_clk_en(bus_clk_en), .periph_stop(periph_stop), .low_voltage_detect_en(low_voltage_detect_en),
   .regulator_low_power(regulator_low_power), .flash_access_strobe(flash_access_strobe),
   .irc_core_src_allow(irc_core_src_allow), .bias_en(bias_en), .io_hold(io_hold),
   .adc_pin_irq_en(adc_pin_irq_en), .lp_periph_allow(lp_periph_allow));

// ===== tb/test_power_mode_sequencer.sv
// Testbench for the power mode sequencer, driving the core model and mode inputs.
// Assumes the one-cycle answer latency of the sequencer.
`timescale 1ns/1ps
`include "pms_regs.vh"
module test_power_mode_sequencer;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg dss = 1'b0;
   reg vreq = 1'b0;
   reg [1:0] ssel = 2'h0;
   reg dcdc = 1'b0;
   reg sleep_go = 1'b0;
   reg irq_go = 1'b0;
   reg [10:0] n;
   wire [`PMS_ST_W-1:0] ms;
   wire sleep_instr, irq, wake, cce, sce, bce, pst, det, rlp, cgu, fsl, stb, irc, bias, ioh, adc, lpp;
   wire [5:0] ctl = {cce, sce, bce, pst, ioh, det};
   wire [3:0] vlp = {rlp, cgu, fsl, irc};
   integer n_errors = 0;
   integer n_tests = 0;
   always #5 clk = ~clk;
   pms_core_model pms_core_model_i (.clk(clk), .rst(rst), .sleep_go(sleep_go), .irq_go(irq_go),
      .core_clk_en(cce), .sleep_instr(sleep_instr), .irq(irq));
   pms_sequencer pms_sequencer_i (.clk(clk), .rst(rst), .wait_for_interrupt_instr(sleep_instr),
      .deep_sleep_select(dss), .irq_pending(irq), .vlp_run_req(vreq), .stop_select(ssel),
      .dcdc_continuous(dcdc), .mode_state(ms), .core_wake(wake), .core_clk_en(cce), .sys_clk_en(sce),
      .bus_clk_en(bce), .periph_stop(pst), .low_voltage_detect_en(det), .regulator_low_power(rlp),
      .clock_generator_unit_vlp(cgu), .flash_slow_access(fsl), .flash_access_strobe(stb),
      .irc_core_src_allow(irc), .bias_en(bias), .io_hold(ioh), .adc_pin_irq_en(adc), .lp_periph_allow(lpp));
   task test_done;
      begin
         $display("Checks: %0d, errors: %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [10:0] got, input [10:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
         end
      end
   endtask
   task cyc(input integer k);
      begin
         repeat (k) @(posedge clk);
         #1;
      end
   endtask
   // Sleeps with the given select, checks the mode, then wakes and checks the return.
   task go(input d, input [1:0] s, input v, input [7:0] st, input [5:0] c, input [3:0] p);
      begin
         @(posedge clk);
         dss <= d;
         ssel <= s;
         sleep_go <= 1'b1;
         @(posedge clk);
         sleep_go <= 1'b0;
         cyc(1);
         chk(ms, st);
         chk({ctl, vlp}, {c, p});
         @(posedge clk);
         irq_go <= 1'b1;
         @(posedge clk);
         irq_go <= 1'b0;
         cyc(1);
         chk({ms, wake}, {v ? 8'h20 : 8'h01, 1'b1});
         chk({ctl, vlp}, v ? 10'h38f : 10'h390);
      end
   endtask
   task t_reset;
      begin
         chk({ms, wake}, 9'h002);
         chk({ctl, vlp}, 10'h390);
         chk({stb, bias, adc, lpp}, 4'hf);
      end
   endtask
   task t_run;
      begin
         go(1'b0, 2'h0, 1'b0, 8'h02, 6'b011011, 4'h0);
         go(1'b1, 2'h0, 1'b0, 8'h04, 6'b000111, 4'h0);
         go(1'b1, 2'h1, 1'b0, 8'h10, 6'b000111, 4'h0);
         go(1'b1, 2'h2, 1'b0, 8'h08, 6'b001011, 4'h0);
         go(1'b1, 2'h3, 1'b0, 8'h04, 6'b000111, 4'h0);
      end
   endtask
   task t_vlp;
      begin
         @(posedge clk);
         vreq <= 1'b1;
         cyc(2);
         chk({ms, bias}, 9'h041);
         @(posedge clk);
         dcdc <= 1'b1;
         cyc(2);
         chk({ms, bias}, 9'h040);
         go(1'b0, 2'h0, 1'b1, 8'h40, 6'b011010, 4'hf);
         go(1'b1, 2'h0, 1'b1, 8'h80, 6'b000110, 4'he);
         go(1'b1, 2'h1, 1'b1, 8'h10, 6'b000110, 4'he);
         go(1'b1, 2'h2, 1'b1, 8'h08, 6'b001010, 4'he);
         n = 11'h000;
         repeat (200) begin
            @(posedge clk);
            #1;
            n = n + stb;
         end
         chk(n, 200 / `PMS_FLASH_DIV_CYC);
         // Measure the exact spacing between two slow strobes; a strobe stuck low ends in the watchdog.
         while (!stb) begin
            cyc(1);
         end
         n = 11'h000;
         cyc(1);
         while (!stb) begin
            n = n + 1'b1;
            cyc(1);
         end
         chk(n, `PMS_FLASH_DIV_CYC - 1);
         @(posedge clk);
         vreq <= 1'b0;
         cyc(2);
         chk({ms, stb, det, bias}, 11'h00f);
      end
   endtask
   // Requests that must be ignored, then a reset taken while asleep.
   task t_refuse;
      begin
         @(posedge clk);
         irq_go <= 1'b1;
         @(posedge clk);
         irq_go <= 1'b0;
         cyc(2);
         chk({ms, wake}, 9'h002);
         @(posedge clk);
         dss <= 1'b0;
         sleep_go <= 1'b1;
         @(posedge clk);
         sleep_go <= 1'b0;
         vreq <= 1'b1;
         cyc(3);
         chk(ms, 8'h02);
         @(posedge clk);
         rst <= 1'b1;
         cyc(2);
         chk(ms, 8'h01);
         @(posedge clk);
         rst <= 1'b0;
         vreq <= 1'b0;
         cyc(2);
         chk({ctl, vlp}, 10'h390);
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      t_reset;
      t_run;
      t_vlp;
      t_refuse;
      test_done;
   end
   // The whole run needs well under two thousand cycles.
   initial begin
      #200000;
      n_errors = n_errors + 1;
      test_done;
   end
endmodule
